// ==== core/reset_cause_decode.v ====
// reset source classifier: picks one cause per cycle by priority
`timescale 1ns/10ps
`include "reset_init_map.vh"
module reset_cause_decode
(
    input wire porEvent,
    input wire pinLowEvent,
    input wire lowSupplyEvent,
    input wire usbResetEvent,
    input wire watchdogExpiry,
    input wire lowPowerMode,
    output reg [2:0] cause
);
    always @*
    begin
        if (porEvent)
            cause = `CAUSE_POR;
        else if (pinLowEvent)
            cause = `CAUSE_PIN;
        else if (lowSupplyEvent)
            cause = `CAUSE_LOWSUP;
        else if (usbResetEvent)
            cause = `CAUSE_USB;
        else if (watchdogExpiry && lowPowerMode)
            cause = `CAUSE_WDT_SLEEP;
        else if (watchdogExpiry)
            cause = `CAUSE_WDT_RUN;
        else
            cause = `CAUSE_NONE;
    end
endmodule

// ==== core/reset_init_map.vh ====
// register offsets, field positions and reset values of the reset initialisation block
`ifndef RESET_INIT_MAP_VH
`define RESET_INIT_MAP_VH
`define OFS_STATUS 12'h000
`define OFS_CAUSE 12'h004
`define OFS_IRQ_STAT 12'h008
`define OFS_IRQ_MASK 12'h00c
`define OFS_CTRL 12'h010
`define OFS_POINTERS 12'h014
`define OFS_CORE 12'h018
`define OFS_IOTMR 12'h01c
`define BIT_PDF 4
`define BIT_TO 5
`define CAUSE_NONE 3'h0
`define CAUSE_POR 3'h1
`define CAUSE_PIN 3'h2
`define CAUSE_LOWSUP 3'h3
`define CAUSE_USB 3'h4
`define CAUSE_WDT_RUN 3'h5
`define CAUSE_WDT_SLEEP 3'h6
`define PTR_RESET 8'h00
`define PC_RESET 13'h0000
`define DIR_INPUT 8'hff
`define WDT_RESET 16'h0000
`endif

// ==== core/reset_source_init_logic.v ====
// reset initialisation logic with flags, core state clearing and apb registers
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "reset_init_map.vh"
// How it works
// (RULE1) watchdog expiry while idle or asleep clears program counter, stack pointer and watchdog counter only
// (RULE2) pin, low-supply or usb reset in normal or slow mode keeps both flags
// (RULE3) watchdog expiry in normal or slow mode sets timeout flag, keeps powerdown
// (RULE4) watchdog expiry while idle or asleep sets timeout and powerdown flags
// (RULE5) flags live in status; sleep entry and watchdog clear also update them
// (RULE6) power-on reset clears timeout and powerdown flags
// (RULE7) power-on reset clears the interrupt enable; the irq mask keeps its value, so irq can still rise
// (RULE8) power-on reset clears the watchdog counter, which then counts at once
// (RULE9) power-on reset switches all timer modules off
// (RULE10) power-on reset makes every general-purpose pin an input
// (RULE11) power-on reset points the stack pointer at the stack top
// (RULE12) all resets clear pointer registers except watchdog expiry while asleep
// (RULE13) external reset pin low resets core and restarts at address zero
module reset_source_init_logic
#(
    parameter PC_WIDTH = 13,
    parameter SP_WIDTH = 4,
    parameter [SP_WIDTH-1:0] STACK_TOP = 4'hf,
    parameter NUM_TIMERS = 3
)
(
    input wire clk_sys,
    input wire rst,
    input wire porEvent,
    input wire external_reset_pin_n,
    input wire low_supply_reset,
    input wire usbReset,
    input wire watchdogExpiry,
    input wire lowPowerMode,
    input wire sleepEntry,
    input wire watchdogClear,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    output wire irq,
    output reg coreResetPulse,
    output reg [PC_WIDTH-1:0] programCounter_q,
    output reg [SP_WIDTH-1:0] stackPointer_q,
    output reg [7:0] indirect_access_port_q,
    output reg [7:0] memory_pointer_q,
    output reg interruptEnable_q,
    output reg [15:0] watchdogCount_q,
    output reg [NUM_TIMERS-1:0] timerOn_q,
    output reg [7:0] ioDirection_q,
    output reg watchdog_expiry_flag_q,
    output reg powerdown_flag_q
);
    wire [2:0] cause;
    wire isPor;
    wire wdtSleep;
    wire fullReset;
    wire apbWrite;
    wire apbRead;
    wire [5:0] events;
    wire clearStat;
    wire [5:0] irqStat_d;
    reg [2:0] lastCause_q;
    reg [5:0] irqStat_q;
    reg [5:0] irqMask_q;
    reg watchdog_expiry_flag_d;
    reg powerdown_flag_d;
    reg [31:0] readWord;
    genvar g;

    function automatic hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    function automatic anyCause;
        input [2:0] code;
        begin
            anyCause = (code != `CAUSE_NONE);
        end
    endfunction

    // one cause per cycle, power-on first
    reset_cause_decode decoder
    (
        .porEvent(porEvent),
        .pinLowEvent(~external_reset_pin_n),
        .lowSupplyEvent(low_supply_reset),
        .usbResetEvent(usbReset),
        .watchdogExpiry(watchdogExpiry),
        .lowPowerMode(lowPowerMode),
        .cause(cause)
    );

    assign isPor = (cause == `CAUSE_POR);
    assign wdtSleep = (cause == `CAUSE_WDT_SLEEP);
    assign fullReset = anyCause(cause) && !wdtSleep;
    assign apbWrite = psel && penable && pwrite;
    assign apbRead = psel && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign irq = |(irqStat_q & irqMask_q);

    // one sticky event per reset source, both watchdog causes sharing bit 4, plus sleep entry
    assign events[0] = isPor;
    assign events[1] = (cause == `CAUSE_PIN);
    assign events[2] = (cause == `CAUSE_LOWSUP);
    assign events[3] = (cause == `CAUSE_USB);
    assign events[4] = (cause == `CAUSE_WDT_RUN) || wdtSleep;
    assign events[5] = sleepEntry;

    // next value of the reset flags; both hold unless something moves them
    always @*
    begin
        watchdog_expiry_flag_d = watchdog_expiry_flag_q;
        powerdown_flag_d = powerdown_flag_q;
        case (cause)
            `CAUSE_POR:
            begin
                watchdog_expiry_flag_d = 1'b0; // [RULE6]
                powerdown_flag_d = 1'b0; // [RULE6]
            end
            `CAUSE_PIN, `CAUSE_LOWSUP, `CAUSE_USB:
            begin
                watchdog_expiry_flag_d = watchdog_expiry_flag_q; // [RULE2]
                powerdown_flag_d = powerdown_flag_q; // [RULE2]
            end
            `CAUSE_WDT_RUN:
                watchdog_expiry_flag_d = 1'b1; // [RULE3]
            `CAUSE_WDT_SLEEP:
            begin
                watchdog_expiry_flag_d = 1'b1; // [RULE4]
                powerdown_flag_d = 1'b1; // [RULE4]
            end
            default:
            begin
                // sleep entry sets powerdown, watchdog clear drops both
                if (sleepEntry)
                begin
                    watchdog_expiry_flag_d = 1'b0; // [RULE5]
                    powerdown_flag_d = 1'b1; // [RULE5]
                end
                else if (watchdogClear)
                begin
                    watchdog_expiry_flag_d = 1'b0; // [RULE5]
                    powerdown_flag_d = 1'b0; // [RULE5]
                end
            end
        endcase
    end

    // reset flags
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            watchdog_expiry_flag_q <= 1'b0; // [RULE6]
            powerdown_flag_q <= 1'b0; // [RULE6]
        end
        else
        begin
            watchdog_expiry_flag_q <= watchdog_expiry_flag_d;
            powerdown_flag_q <= powerdown_flag_d;
        end
    end

    // core state initialisation
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            programCounter_q <= `PC_RESET;
            stackPointer_q <= STACK_TOP;
            indirect_access_port_q <= `PTR_RESET;
            memory_pointer_q <= `PTR_RESET;
            interruptEnable_q <= 1'b0;
            watchdogCount_q <= `WDT_RESET;
            timerOn_q <= {NUM_TIMERS{1'b0}};
            ioDirection_q <= `DIR_INPUT;
            coreResetPulse <= 1'b1;
            lastCause_q <= `CAUSE_POR;
        end
        else
        begin
            coreResetPulse <= anyCause(cause); // [RULE13]
            if (anyCause(cause))
                lastCause_q <= cause;
            // a reset cause outranks any pointer, io/timer or control register write in the same cycle
            if (wdtSleep)
            begin
                programCounter_q <= `PC_RESET; // [RULE1]
                stackPointer_q <= {SP_WIDTH{1'b0}}; // [RULE1]
            end
            else if (fullReset)
            begin
                programCounter_q <= `PC_RESET; // [RULE13]
                stackPointer_q <= STACK_TOP; // [RULE11]
                indirect_access_port_q <= `PTR_RESET; // [RULE12]
                memory_pointer_q <= `PTR_RESET; // [RULE12]
                interruptEnable_q <= 1'b0; // [RULE7]
                timerOn_q <= {NUM_TIMERS{1'b0}}; // [RULE9]
                ioDirection_q <= `DIR_INPUT; // [RULE10]
            end
            else if (apbWrite && hit(paddr, `OFS_POINTERS))
            begin
                indirect_access_port_q <= pwdata[7:0];
                memory_pointer_q <= pwdata[15:8];
            end
            else if (apbWrite && hit(paddr, `OFS_IOTMR))
            begin
                ioDirection_q <= pwdata[7:0];
                timerOn_q <= pwdata[8 +: NUM_TIMERS];
            end
            else if (apbWrite && hit(paddr, `OFS_CTRL))
                interruptEnable_q <= pwdata[0];
            else
                programCounter_q <= programCounter_q + {{(PC_WIDTH-1){1'b0}}, 1'b1};
            // watchdog restarts counting from zero right after reset
            if (fullReset || watchdogClear || wdtSleep)
            begin
                watchdogCount_q <= `WDT_RESET; // [RULE8]
            end
            else
            begin
                watchdogCount_q <= watchdogCount_q + 16'h0001; // [RULE8]
            end
        end
    end

    // sticky status, set wins over write-one-to-clear
    assign clearStat = apbWrite && hit(paddr, `OFS_IRQ_STAT);
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : stickyBit
            assign irqStat_d[g] = events[g] || (irqStat_q[g] && !(clearStat && pwdata[g]));
        end
    endgenerate

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            irqStat_q <= 6'h00;
            irqMask_q <= 6'h00;
        end
        else
        begin
            irqStat_q <= irqStat_d;
            if (apbWrite && hit(paddr, `OFS_IRQ_MASK))
                irqMask_q <= pwdata[5:0];
        end
    end

    // read word by offset; unmapped offsets read zero
    always @*
    begin
        readWord = 32'h00000000;
        case (paddr)
            `OFS_STATUS:
            begin
                readWord[`BIT_TO] = watchdog_expiry_flag_q;
                readWord[`BIT_PDF] = powerdown_flag_q;
            end
            `OFS_CAUSE:
                readWord[2:0] = lastCause_q;
            `OFS_IRQ_STAT:
                readWord[5:0] = irqStat_q;
            `OFS_IRQ_MASK:
                readWord[5:0] = irqMask_q;
            `OFS_CTRL:
                readWord[0] = interruptEnable_q;
            `OFS_POINTERS:
                readWord[15:0] = {memory_pointer_q, indirect_access_port_q};
            `OFS_CORE:
            begin
                readWord[SP_WIDTH-1:0] = stackPointer_q;
                readWord[23:8] = watchdogCount_q;
            end
            `OFS_IOTMR:
            begin
                readWord[7:0] = ioDirection_q;
                readWord[8 +: NUM_TIMERS] = timerOn_q;
            end
            default:
                readWord = 32'h00000000;
        endcase
    end

    // read data taken in the setup cycle, so it stands through the access phase
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            prdata <= 32'h00000000;
        else if (apbRead && !penable)
            prdata <= readWord;
    end
endmodule

// ==== test/reset_source_init_logic_monitor.sv ====
// assertion checker for the reset initialisation block
`timescale 1ns/10ps
module reset_source_init_logic_monitor
#(
    parameter PC_WIDTH = 13,
    parameter SP_WIDTH = 4,
    parameter [SP_WIDTH-1:0] STACK_TOP = 4'hf,
    parameter NUM_TIMERS = 3
)
(
    input wire clk_sys,
    input wire rst,
    input wire porEvent,
    input wire external_reset_pin_n,
    input wire low_supply_reset,
    input wire usbReset,
    input wire watchdogExpiry,
    input wire lowPowerMode,
    input wire sleepEntry,
    input wire watchdogClear,
    input wire coreResetPulse,
    input wire [PC_WIDTH-1:0] programCounter_q,
    input wire [SP_WIDTH-1:0] stackPointer_q,
    input wire [7:0] indirect_access_port_q,
    input wire [7:0] memory_pointer_q,
    input wire interruptEnable_q,
    input wire [15:0] watchdogCount_q,
    input wire [NUM_TIMERS-1:0] timerOn_q,
    input wire [7:0] ioDirection_q,
    input wire watchdog_expiry_flag_q,
    input wire powerdown_flag_q
);
    // causes after priority
    wire other = !porEvent && (!external_reset_pin_n || low_supply_reset || usbReset);
    wire wdt = !porEvent && !other && watchdogExpiry;
    wire wdtSleep = wdt && lowPowerMode;
    wire anyRst = porEvent || other || wdt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence porThenQuiet;
        porEvent ##1 !(anyRst || watchdogClear);
    endsequence
    sleep_wdt_core_a: assert property (wdtSleep |=> programCounter_q == 0 &&
        stackPointer_q == 0 && $stable(indirect_access_port_q) && $stable(memory_pointer_q))
        else $error("core state after sleep expiry");
    keep_flags_a: assert property (other && !lowPowerMode |=>
        $stable(watchdog_expiry_flag_q) && $stable(powerdown_flag_q)) else $error("flags moved");
    run_wdt_flag_a: assert property (wdt && !lowPowerMode |=>
        watchdog_expiry_flag_q && $stable(powerdown_flag_q)) else $error("run expiry flags");
    sleep_wdt_flags_a: assert property (wdtSleep |=>
        watchdog_expiry_flag_q && powerdown_flag_q) else $error("sleep expiry flags");
    sleep_entry_flags_a: assert property (sleepEntry && !anyRst |=>
        !watchdog_expiry_flag_q && powerdown_flag_q) else $error("sleep entry flags");
    por_flags_a: assert property (porEvent |=>
        !watchdog_expiry_flag_q && !powerdown_flag_q) else $error("power-on flags");
    por_state_a: assert property (porEvent |=> !interruptEnable_q && timerOn_q == 0 &&
        ioDirection_q == 8'hff && stackPointer_q == STACK_TOP) else $error("power-on state");
    por_watchdog_a: assert property (porThenQuiet |->
        watchdogCount_q == 0 ##1 watchdogCount_q == 16'h0001) else $error("watchdog count");
    pointer_clear_a: assert property (anyRst && !wdtSleep |=>
        indirect_access_port_q == 0 && memory_pointer_q == 0) else $error("pointers kept");
    pc_restart_a: assert property (anyRst |=>
        programCounter_q == 0 && coreResetPulse) else $error("restart address");
endmodule
bind reset_source_init_logic reset_source_init_logic_monitor #(.PC_WIDTH(PC_WIDTH),
    .SP_WIDTH(SP_WIDTH), .STACK_TOP(STACK_TOP), .NUM_TIMERS(NUM_TIMERS)) i_monitor (.*);

// ==== test/tb.sv ====
// self-checking bench for the reset initialisation block
`timescale 1ns/10ps
`include "reset_init_map.vh"
module tb;
    logic clk_sys = 0, rst = 1, porEvent = 0, external_reset_pin_n = 1, low_supply_reset = 0;
    logic usbReset = 0, watchdogExpiry = 0, lowPowerMode = 0, sleepEntry = 0, watchdogClear = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, coreResetPulse;
    logic interruptEnable_q, watchdog_expiry_flag_q, powerdown_flag_q, toE = 0, pdfE = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [12:0] programCounter_q;
    logic [3:0] stackPointer_q;
    logic [7:0] indirect_access_port_q, memory_pointer_q, ioDirection_q;
    logic [15:0] watchdogCount_q, ptr;
    logic [2:0] timerOn_q;
    logic [63:0] rdq[$], rsq[$], e;
    logic armed = 0;
    logic [2:0] causeE = `CAUSE_POR;
    int num_errors = 0, n_compared = 0, cyc = 0, seed = 23740, i;
    reset_source_init_logic i_reset_source_init_logic (.*);
    always #2 clk_sys = ~clk_sys;
    task stop_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // read expectation goes on pwdata too; harmless for reads
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        if (!wr)
            rdq.push_back({m, d & m});
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        psel <= 0;
        penable <= 0;
    endtask
    // 0 por 1 pin 2 lowsup 3 usb 4 watchdog 5 sleep entry 6 watchdog clear
    task fire(input int kind, input logic lp);
        ptr = 16'($random(seed));
        apb(1, `OFS_POINTERS, {16'h0, ptr}, 0);
        @(posedge clk_sys);
        lowPowerMode <= lp && kind == 4;
        porEvent <= kind == 0;
        external_reset_pin_n <= kind != 1;
        low_supply_reset <= kind == 2;
        usbReset <= kind == 3;
        watchdogExpiry <= kind == 4;
        sleepEntry <= kind == 5;
        watchdogClear <= kind == 6;
        if (kind < 5)
            rsq.push_back(kind == 4 && lp ? {4'h0, ptr} : {4'hf, 16'h0});
        if (kind < 5)
            causeE = kind == 4 ? (lp ? `CAUSE_WDT_SLEEP : `CAUSE_WDT_RUN) : 3'(kind + 1);
        if (kind == 0 || kind == 6)
            {toE, pdfE} = 2'b00;
        if (kind == 4)
            toE = 1;
        if (kind == 4 && lp)
            pdfE = 1;
        if (kind == 5)
            {toE, pdfE} = 2'b01;
        @(posedge clk_sys);
        {porEvent, low_supply_reset, usbReset, watchdogExpiry} <= 4'h0;
        {lowPowerMode, sleepEntry, watchdogClear, external_reset_pin_n} <= 4'h1;
        apb(0, `OFS_STATUS, {toE, pdfE, 4'h0}, 32'h30);
        apb(0, `OFS_CAUSE, {29'h0, causeE}, 32'h7);
    endtask
    always @(posedge clk_sys)
    begin
        if (psel && penable && !pwrite && pready)
        begin
            e = rdq.pop_front();
            check("prdata", e[31:0], prdata & e[63:32]);
            check("pslverr", 0, {31'h0, pslverr});
        end
        if (armed && coreResetPulse)
        begin
            e = rsq.pop_front();
            check("pc", 0, {19'h0, programCounter_q});
            check("core", e[31:0], {12'h0, stackPointer_q, memory_pointer_q, indirect_access_port_q});
        end
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            stop_test();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 0;
        repeat (2) @(posedge clk_sys);
        armed <= 1;
        apb(0, `OFS_STATUS, 0, 32'h30);
        apb(1, `OFS_CTRL, 1, 0);
        apb(1, `OFS_IOTMR, 32'h700, 0);
        fire(0, 0);
        apb(0, `OFS_CTRL, 0, 32'h1);
        apb(0, `OFS_IOTMR, 32'hff, 32'h7ff);
        apb(0, `OFS_CORE, 32'hf, 32'hf);
        apb(0, 12'h100, 0, 32'hffffffff);
        for (i = 0; i < 14; i++)
            fire(i % 7, 1'(i / 7));
        apb(1, `OFS_IRQ_MASK, 0, 0);
        #1 check("irq", 0, {31'h0, irq});
        apb(1, `OFS_IRQ_MASK, 32'h3f, 0);
        #1 check("irq", 1, {31'h0, irq});
        apb(1, `OFS_IRQ_STAT, 32'h3f, 0);
        #1 check("irq", 0, {31'h0, irq});
        fire(1, 0);
        #1 check("irq", 1, {31'h0, irq});
        apb(0, `OFS_IRQ_STAT, 2, 32'h3f);
        for (i = 0; i < 20; i++)
            fire(int'({$random(seed)} % 7), 1'($random(seed)));
        stop_test();
    end
endmodule
